//--- fpio_top.sv
// Four-port parallel I/O block with Avalon-MM register slave
// Notes on behaviour
// - 31 pins in three 8-bit ports and one 7-bit port, each direction-set.
// - Port A data at index 0x0000, direction at 0x0004; no shared pins.
// - Port B data at index 0x0001, direction at 0x0005, both 8 bits.
// - Port C data at index 0x0002, direction at 0x0006, both 8 bits.
// - Reset clears all direction bits; data latches keep their contents.
// - Direction bit 1 drives pin from data latch; 0 leaves it input.
// - Data latches are undefined at power-up; software initialises them.
// - Port B pins get interrupts, enabled per bit by option at 0x3FF0.
// - Enabled port B interrupt pin configured as input gets a pullup.
// - Port B interrupts use the dedicated interrupt pin's sensitivity.
// - Port D bidirectional in full config, input-only in ROM-compatible.
// - Port D shares four pins with SPI, one with the SCI transmit driver.
// - Reset makes all port D pins inputs, serial drivers disabled.
`default_nettype none
module fpio_top
    import fpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [FPIO_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pa_pin_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pa_pin_oe,
    input wire logic [7:0] pb_pin_in,
    output logic [7:0] pb_pin_out,
    output logic [7:0] pb_pin_oe,
    output logic [7:0] pb_pullup_en,
    input wire logic [7:0] pc_pin_in,
    output logic [7:0] pc_pin_out,
    output logic [7:0] pc_pin_oe,
    input wire logic [6:0] pd_pin_in,
    output logic [6:0] pd_pin_out,
    output logic [6:0] pd_pin_oe,
    output logic [6:0] pd_pin_level,
    input wire logic full_port_configuration,
    input wire logic sci_tx_drv_en,
    input wire logic sci_tx_data,
    input wire logic [3:0] spi_drv_en,
    input wire logic [3:0] spi_data,
    output logic irq
);
    fpio_bus_e bus_state_r;
    logic [31:0] rdata_nxt;
    logic [7:0] pa_dat_r, pb_dat_r, pc_dat_r;
    logic [6:0] pd_dat_r;
    logic [7:0] pa_dir_r, pb_dir_r, pc_dir_r;
    logic [6:0] pd_dir_r;
    logic [7:0] opt_r, stat_r, mask_r;
    logic level_mode_r;
    logic cfg_full_r;
    logic [7:0] pa_sync, pb_sync, pc_sync;
    logic [6:0] pd_sync;
    logic cfg_sync;
    logic take, wr_lane;
    logic [7:0] wbyte;
    logic [6:0] sfn_en, sfn_dat;

    fpio_irq_if irq_bus ();

    fpio_pin_sync #(.W(32)) u_sync (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .async_in({full_port_configuration, pd_pin_in, pc_pin_in,
                   pb_pin_in, pa_pin_in}),
        .sync_out({cfg_sync, pd_sync, pc_sync, pb_sync, pa_sync})
    );

    fpio_irq_detect u_kbi (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .irq(irq_bus.detect)
    );

    assign irq_bus.lvl = pb_sync;
    assign irq_bus.arm = opt_r & ~pb_dir_r;
    assign irq_bus.level_mode = level_mode_r;

    // Bus handshake: one wait cycle, answer in the next
    assign take = (bus_state_r == FPIO_BUS_ANSWER) && clk_en;
    assign wr_lane = take && avs_write && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bus_state_r <= FPIO_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            case (bus_state_r)
                FPIO_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_r <= FPIO_BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                FPIO_BUS_ANSWER: begin
                    bus_state_r <= FPIO_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state_r <= FPIO_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read decode; unmapped indices read zero
    always_comb begin
        rdata_nxt = RDATA_RST;
        case (avs_address)
            IDX_PA_DATA: rdata_nxt[7:0] = fpio_read_mix(pa_dir_r, pa_dat_r,
                                                        pa_sync);
            IDX_PB_DATA: rdata_nxt[7:0] = fpio_read_mix(pb_dir_r, pb_dat_r,
                                                        pb_sync);
            IDX_PC_DATA: rdata_nxt[7:0] = fpio_read_mix(pc_dir_r, pc_dat_r,
                                                        pc_sync);
            IDX_PD_DATA: rdata_nxt[7:0] = fpio_read_mix({1'b0, pd_dir_r},
                                  {1'b0, pd_dat_r}, {1'b0, pd_sync});
            IDX_PA_DIR: rdata_nxt[7:0] = pa_dir_r;
            IDX_PB_DIR: rdata_nxt[7:0] = pb_dir_r;
            IDX_PC_DIR: rdata_nxt[7:0] = pc_dir_r;
            IDX_PD_DIR: rdata_nxt[6:0] = pd_dir_r;
            IDX_CTRL: begin
                rdata_nxt[CTRL_LEVEL_BIT] = level_mode_r;
                rdata_nxt[CTRL_FULL_BIT] = cfg_full_r;
            end
            IDX_INT_STAT: rdata_nxt[7:0] = stat_r;
            IDX_INT_MASK: rdata_nxt[7:0] = mask_r;
            IDX_PB_OPT: rdata_nxt[7:0] = opt_r;
            default: rdata_nxt = RDATA_RST;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_readdata <= RDATA_RST;
        end else if (clk_en && bus_state_r == FPIO_BUS_IDLE && avs_read) begin
            avs_readdata <= rdata_nxt;
        end
    end

    // Data latches have no reset on purpose
    always_ff @(posedge sys_clk) begin
        if (wr_lane) begin
            if (avs_address == IDX_PA_DATA) pa_dat_r <= wbyte;
            if (avs_address == IDX_PB_DATA) pb_dat_r <= wbyte;
            if (avs_address == IDX_PC_DATA) pc_dat_r <= wbyte;
            if (avs_address == IDX_PD_DATA) pd_dat_r <= wbyte[6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pa_dir_r <= DIR_RST;
            pb_dir_r <= DIR_RST;
            pc_dir_r <= DIR_RST;
            pd_dir_r <= PD_DIR_RST;
        end else if (wr_lane) begin
            if (avs_address == IDX_PA_DIR) pa_dir_r <= wbyte;
            if (avs_address == IDX_PB_DIR) pb_dir_r <= wbyte;
            if (avs_address == IDX_PC_DIR) pc_dir_r <= wbyte;
            if (avs_address == IDX_PD_DIR && cfg_full_r) begin
                pd_dir_r <= wbyte[6:0];
            end
        end
    end

    // Strap caught while reset is held, stable afterwards
    always_ff @(posedge sys_clk) begin
        if (sys_rst && clk_en) begin
            cfg_full_r <= cfg_sync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            opt_r <= OPT_RST;
            mask_r <= MASK_RST;
            level_mode_r <= 1'b0;
        end else if (wr_lane) begin
            if (avs_address == IDX_PB_OPT) opt_r <= wbyte;
            if (avs_address == IDX_INT_MASK) mask_r <= wbyte;
            if (avs_address == IDX_CTRL) begin
                level_mode_r <= wbyte[CTRL_LEVEL_BIT];
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stat_r <= STAT_RST;
        end else if (clk_en) begin
            stat_r <= (stat_r & ~((wr_lane && avs_address == IDX_INT_STAT) ?
                      wbyte : STAT_RST)) | irq_bus.evt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(stat_r & mask_r);
        end
    end

    // Serial peripherals take their pins over when their drivers are on
    always_comb begin
        sfn_en = '0;
        sfn_dat = '0;
        sfn_en[PD_SCI_TX_BIT] = sci_tx_drv_en;
        sfn_dat[PD_SCI_TX_BIT] = sci_tx_data;
        sfn_en[PD_SPI_LSB +: PD_SPI_N] = spi_drv_en;
        sfn_dat[PD_SPI_LSB +: PD_SPI_N] = spi_data;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pa_pin_oe <= DIR_RST;
            pb_pin_oe <= DIR_RST;
            pc_pin_oe <= DIR_RST;
            pd_pin_oe <= PD_DIR_RST;
            pa_pin_out <= DIR_RST;
            pb_pin_out <= DIR_RST;
            pc_pin_out <= DIR_RST;
            pd_pin_out <= PD_DIR_RST;
            pb_pullup_en <= OPT_RST;
            pd_pin_level <= PD_DIR_RST;
        end else if (clk_en) begin
            pa_pin_oe <= pa_dir_r;
            pb_pin_oe <= pb_dir_r;
            pc_pin_oe <= pc_dir_r;
            pd_pin_oe <= pd_dir_r | sfn_en;
            pa_pin_out <= pa_dat_r;
            pb_pin_out <= pb_dat_r;
            pc_pin_out <= pc_dat_r;
            pd_pin_out <= (sfn_en & sfn_dat) | (~sfn_en & pd_dat_r);
            pb_pullup_en <= opt_r & ~pb_dir_r;
            pd_pin_level <= pd_sync;
        end
    end

    // Checks
    dir_reset_a: assert property (@(posedge sys_clk)
        sys_rst |=> (pa_dir_r | pb_dir_r | pc_dir_r) == DIR_RST
                    && pd_dir_r == PD_DIR_RST)
        else $error("direction not cleared by reset");
    pd_reset_in_a: assert property (@(posedge sys_clk)
        sys_rst |=> pd_pin_oe == PD_DIR_RST)
        else $error("port D driven during reset");
    pa_drive_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (wr_lane && avs_address == IDX_PA_DIR) ##1 clk_en
        |=> pa_pin_oe == $past(wbyte, 2))
        else $error("port A enable does not follow direction write");
    pc_write_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (wr_lane && avs_address == IDX_PC_DATA) |=> pc_dat_r == $past(wbyte))
        else $error("port C data write lost");
    pb_read_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (clk_en && bus_state_r == FPIO_BUS_IDLE && avs_read
         && avs_address == IDX_PB_DATA)
        |=> avs_readdata[7:0] == $past(fpio_read_mix(pb_dir_r, pb_dat_r,
                                        pb_sync)) && !avs_waitrequest)
        else $error("port B read mismatch");
    rom_cfg_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        !cfg_full_r |-> pd_dir_r == PD_DIR_RST)
        else $error("port D direction set in ROM-compatible config");
    pullup_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        clk_en |=> pb_pullup_en == $past(opt_r & ~pb_dir_r))
        else $error("pullup does not follow option and direction");
    no_arm_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        clk_en |=> (stat_r & ~$past(stat_r) & ~$past(opt_r)) == STAT_RST)
        else $error("status set on a disabled pin");
    // Pin watched for level sensitivity
    localparam int unsigned LVL_CHK_BIT = 5;
    level_sens_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (clk_en && level_mode_r && opt_r[LVL_CHK_BIT]
         && !pb_dir_r[LVL_CHK_BIT] && !pb_sync[LVL_CHK_BIT])
        |=> stat_r[LVL_CHK_BIT]
            ##1 (!$past(clk_en) || !$past(mask_r[LVL_CHK_BIT]) || irq))
        else $error("level interrupt not taken");
    pa_word_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (wr_lane && avs_address == IDX_PA_DATA) |=> pa_dat_r == $past(wbyte))
        else $error("port A data write lost");
    pb_dir_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (wr_lane && avs_address == IDX_PB_DIR) |=> pb_dir_r == $past(wbyte))
        else $error("port B direction write lost");
    sfn_drive_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (clk_en && spi_drv_en[0]) |=> pd_pin_oe[PD_SPI_LSB]
            && pd_pin_out[PD_SPI_LSB] == $past(spi_data[0]))
        else $error("SPI driver did not take the pin");
    pd_data_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (wr_lane && avs_address == IDX_PD_DATA)
        |=> pd_dat_r == $past(wbyte[6:0]))
        else $error("port D data write lost");
    irq_level_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        clk_en |=> irq == ($past(stat_r & mask_r) != STAT_RST))
        else $error("interrupt output does not follow status and mask");
    all_in_reset_a: assert property (@(posedge sys_clk)
        sys_rst |=> (pa_pin_oe | pb_pin_oe | pc_pin_oe) == DIR_RST)
        else $error("port pins driven during reset");
    pd_rom_oe_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (!cfg_full_r && clk_en)
        |=> (pd_pin_oe & ~$past(sfn_en)) == PD_DIR_RST)
        else $error("port D pin driven in ROM-compatible config");
    ack_one_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (!avs_waitrequest && clk_en) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // Scenario covers
    kbi_irq_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        irq_bus.evt != STAT_RST ##[1:3] irq);
    w1c_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        stat_r != STAT_RST && wr_lane && avs_address == IDX_INT_STAT);
    pd_out_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        cfg_full_r && pd_dir_r != PD_DIR_RST);
    lvl_mode_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        level_mode_r && stat_r != STAT_RST);
    rom_dir_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        !cfg_full_r && wr_lane && avs_address == IDX_PD_DIR);
endmodule : fpio_top
`default_nettype wire

//--- fpio_pkg.sv
// Package of offsets, field positions and types for the parallel port block
`default_nettype none
package fpio_pkg;
    localparam int unsigned FPIO_AW = 14;
    localparam int unsigned FPIO_PW = 8;
    localparam int unsigned FPIO_DW = 7;
    // Word indices; byte address is four times the index
    localparam logic [13:0] IDX_PA_DATA = 14'h0000;
    localparam logic [13:0] IDX_PB_DATA = 14'h0001;
    localparam logic [13:0] IDX_PC_DATA = 14'h0002;
    localparam logic [13:0] IDX_PD_DATA = 14'h0003;
    localparam logic [13:0] IDX_PA_DIR = 14'h0004;
    localparam logic [13:0] IDX_PB_DIR = 14'h0005;
    localparam logic [13:0] IDX_PC_DIR = 14'h0006;
    localparam logic [13:0] IDX_PD_DIR = 14'h0007;
    localparam logic [13:0] IDX_CTRL = 14'h0010;
    localparam logic [13:0] IDX_INT_STAT = 14'h0011;
    localparam logic [13:0] IDX_INT_MASK = 14'h0012;
    localparam logic [13:0] IDX_PB_OPT = 14'h3ff0;
    // Field positions
    localparam int unsigned CTRL_LEVEL_BIT = 0;
    localparam int unsigned CTRL_FULL_BIT = 1;
    localparam int unsigned PD_SCI_TX_BIT = 1;
    localparam int unsigned PD_SPI_LSB = 2;
    localparam int unsigned PD_SPI_N = 4;
    // Reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [6:0] PD_DIR_RST = 7'h00;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic {FPIO_BUS_IDLE, FPIO_BUS_ANSWER} fpio_bus_e;

    // Output pins read back their latch, input pins their level
    function automatic logic [7:0] fpio_read_mix(input logic [7:0] dir,
                                                 input logic [7:0] dat,
                                                 input logic [7:0] pin);
        fpio_read_mix = (dir & dat) | (~dir & pin);
    endfunction : fpio_read_mix
endpackage : fpio_pkg
`default_nettype wire

//--- fpio_irq_if.sv
// Interface between the port core and the keyboard interrupt detector
`default_nettype none
interface fpio_irq_if;
    logic [7:0] lvl;
    logic [7:0] arm;
    logic level_mode;
    logic [7:0] evt;
    modport core (output lvl, output arm, output level_mode, input evt);
    modport detect (input lvl, input arm, input level_mode, output evt);
endinterface : fpio_irq_if
`default_nettype wire

//--- fpio_pin_sync.sv
// Two-stage synchroniser for pin inputs
`default_nettype none
module fpio_pin_sync #(
    parameter int unsigned W = 8
) (
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : fpio_pin_sync
`default_nettype wire

//--- fpio_irq_detect.sv
// Falling-edge and low-level detector for the interrupt-capable port pins
`default_nettype none
module fpio_irq_detect
    import fpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    fpio_irq_if.detect irq
);
    logic [7:0] prev_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_r <= {FPIO_PW{1'b1}};
        end else if (clk_en) begin
            prev_r <= irq.lvl;
        end
    end

    // Active low, like the dedicated interrupt pin
    assign irq.evt = irq.arm & ((prev_r & ~irq.lvl) |
                     ({FPIO_PW{irq.level_mode}} & ~irq.lvl));
endmodule : fpio_irq_detect
`default_nettype wire

//--- fpio_pins_model.sv
// Board-side model of the port pins: drivers, pullups and released lines
`default_nettype none
module fpio_pins_model #(
    parameter int unsigned W = 8
) (
    input wire logic sys_clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pull_en,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin_lvl
);
    // Undriven lines toggle so a stale value never reads as valid
    logic [W-1:0] float_r = '0;
    always_ff @(posedge sys_clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = float_r[i];
            end
        end
    end
endmodule : fpio_pins_model
`default_nettype wire

//--- fpio_top_tb.sv
// Self-checking bench for the four-port parallel I/O block
`default_nettype none
module fpio_top_tb
    import fpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [13:0] widx;
        logic [7:0] wd;
        logic [13:0] ridx;
        logic [7:0] exp;
    } fpio_row_s;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic full_port_configuration = 1'b1;
    logic sci_tx_drv_en = 1'b0;
    logic sci_tx_data = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic [31:0] rd_q;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] spi_drv_en = 4'h0;
    logic [3:0] spi_data = 4'h0;
    logic avs_waitrequest, irq;
    logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe;
    logic [7:0] pb_pin_in, pb_pin_out, pb_pin_oe, pb_pullup_en;
    logic [7:0] pc_pin_in, pc_pin_out, pc_pin_oe;
    logic [6:0] pd_pin_in, pd_pin_out, pd_pin_oe, pd_pin_level;
    logic [7:0] ext_a = 8'h3c;
    logic [7:0] ext_b = 8'hff;
    logic [7:0] ext_c = 8'hc3;
    logic [6:0] ext_d = 7'h55;
    logic [7:0] ext_en_ac = 8'hff;
    logic [7:0] ext_en_b = 8'hff;
    logic [7:0] pull_ac = 8'h00;
    logic [6:0] ext_en_d = 7'h7f;
    logic [6:0] pull_d = 7'h00;
    int n_errors = 0;
    int check_count = 0;
    // Software order: data before direction, latches set before use
    fpio_row_s rows [12] = '{
        '{IDX_PA_DATA, 8'h5a, IDX_PA_DATA, 8'h3c},
        '{IDX_PA_DIR, 8'hf0, IDX_PA_DATA, 8'h5c},
        '{IDX_PB_DATA, 8'ha5, IDX_PB_DIR, 8'h00},
        '{IDX_PB_DIR, 8'h0f, IDX_PB_DATA, 8'hf5},
        '{IDX_PC_DATA, 8'h96, IDX_PC_DATA, 8'hc3},
        '{IDX_PC_DIR, 8'hff, IDX_PC_DATA, 8'h96},
        '{IDX_PD_DATA, 8'h2a, IDX_PD_DATA, 8'h55},
        '{IDX_PD_DIR, 8'hff, IDX_PD_DIR, 8'h7f},
        '{IDX_PD_DIR, 8'h0f, IDX_PD_DATA, 8'h5a},
        '{14'h0020, 8'hff, 14'h0020, 8'h00},
        '{IDX_PB_OPT, 8'h3c, IDX_PB_OPT, 8'h3c},
        '{IDX_INT_MASK, 8'hff, IDX_INT_MASK, 8'hff}
    };

    fpio_top dut (.sys_clk, .sys_rst, .clk_en, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pb_pin_in,
        .pb_pin_out, .pb_pin_oe, .pb_pullup_en, .pc_pin_in, .pc_pin_out,
        .pc_pin_oe, .pd_pin_in, .pd_pin_out, .pd_pin_oe, .pd_pin_level,
        .full_port_configuration, .sci_tx_drv_en, .sci_tx_data,
        .spi_drv_en, .spi_data, .irq);
    fpio_pins_model pins_a (.sys_clk, .pin_out(pa_pin_out),
        .pin_oe(pa_pin_oe), .pull_en(pull_ac), .ext_en(ext_en_ac),
        .ext_val(ext_a), .pin_lvl(pa_pin_in));
    fpio_pins_model pins_b (.sys_clk, .pin_out(pb_pin_out),
        .pin_oe(pb_pin_oe), .pull_en(pb_pullup_en), .ext_en(ext_en_b),
        .ext_val(ext_b), .pin_lvl(pb_pin_in));
    fpio_pins_model pins_c (.sys_clk, .pin_out(pc_pin_out),
        .pin_oe(pc_pin_oe), .pull_en(pull_ac), .ext_en(ext_en_ac),
        .ext_val(ext_c), .pin_lvl(pc_pin_in));
    fpio_pins_model #(.W(7)) pins_d (.sys_clk, .pin_out(pd_pin_out),
        .pin_oe(pd_pin_oe), .pull_en(pull_d), .ext_en(ext_en_d),
        .ext_val(ext_d), .pin_lvl(pd_pin_in));

    always #2 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic [13:0] a, input logic rd,
                       input logic [7:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge keeps the strobes from being set twice in one step
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        bus(a, 1'b0, d, 4'hf);
    endtask : wr

    task automatic rd_chk(input logic [13:0] a, input logic [7:0] exp);
        bus(a, 1'b1, 8'h00, 4'hf);
        check(rd_q[7:0], exp);
        check({7'h00, rd_q[31:8] !== 24'h00_0000}, 8'h00);
    endtask : rd_chk

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check({7'h00, irq}, {7'h00, v});
    endtask : wait_irq

    task automatic do_reset(input logic strap);
        sys_rst <= 1'b1;
        full_port_configuration <= strap;
        repeat (6) @(posedge sys_clk);
        check(pa_pin_oe | pb_pin_oe | pc_pin_oe, 8'h00);
        check({1'b0, pd_pin_oe} | pb_pullup_en, 8'h00);
        check({6'h00, irq, avs_waitrequest}, 8'h01);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end

    initial begin
        do_reset(1'b1);
        for (int i = 0; i < 12; i++) begin
            wr(rows[i].widx, rows[i].wd);
            // Pins turned to input need the synchroniser delay
            repeat (4) @(posedge sys_clk);
            rd_chk(rows[i].ridx, rows[i].exp);
        end
        check(pa_pin_oe, 8'hf0);
        check(pa_pin_out & 8'hf0, 8'h50);
        check(pc_pin_out, 8'h96);
        check(pb_pullup_en, 8'h30);
        // Pin 6 has no option bit, so its fall must stay silent
        ext_b <= 8'haf;
        wait_irq(1'b1);
        rd_chk(IDX_INT_STAT, 8'h10);
        wr(IDX_INT_STAT, 8'h10);
        rd_chk(IDX_INT_STAT, 8'h00);
        wait_irq(1'b0);
        wr(IDX_INT_MASK, 8'h00);
        ext_b <= 8'h8f;
        repeat (8) @(posedge sys_clk);
        rd_chk(IDX_INT_STAT, 8'h20);
        check({7'h00, irq}, 8'h00);
        wr(IDX_INT_MASK, 8'h20);
        wait_irq(1'b1);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_INT_STAT, 8'h30);
        rd_chk(IDX_INT_STAT, 8'h30);
        wr(IDX_CTRL, 8'h00);
        ext_b <= 8'hff;
        repeat (8) @(posedge sys_clk);
        wr(IDX_INT_STAT, 8'h30);
        wait_irq(1'b0);
        wr(IDX_PB_DATA, 8'hff);
        wr(IDX_PB_DIR, 8'h00);
        @(posedge sys_clk);
        check(pb_pullup_en, 8'h3c);
        // Released pin with pullup on must read high and stay silent
        ext_en_b <= 8'hfb;
        ext_b <= 8'hfb;
        repeat (4) @(posedge sys_clk);
        rd_chk(IDX_PB_DATA, 8'hff);
        rd_chk(IDX_INT_STAT, 8'h00);
        spi_drv_en <= 4'h5;
        spi_data <= 4'h1;
        sci_tx_drv_en <= 1'b1;
        sci_tx_data <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check({1'b0, pd_pin_oe}, 8'h1f);
        check({3'h0, pd_pin_out[4:0]}, 8'h0e);
        check({7'h00, pd_pin_level[1]}, 8'h01);
        // Serial drivers still requested: reset must hold them off
        do_reset(1'b0);
        wr(IDX_PA_DIR, 8'hff);
        rd_chk(IDX_PA_DATA, 8'h5a);
        bus(IDX_PA_DATA, 1'b0, 8'h00, 4'h0);
        rd_chk(IDX_PA_DATA, 8'h5a);
        wr(IDX_PD_DIR, 8'h7f);
        rd_chk(IDX_PD_DIR, 8'h00);
        check({1'b0, pd_pin_oe} & 8'h41, 8'h00);
        rd_chk(IDX_CTRL, 8'h00);
        // Frozen enable must hold the synchronisers and the pd_pin_level outputs
        clk_en <= 1'b0;
        ext_d <= 7'h2a;
        repeat (4) @(posedge sys_clk);
        check({1'b0, pd_pin_level & 7'h69}, 8'h41);
        clk_en <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({1'b0, pd_pin_level & 7'h69}, 8'h28);
        stop_test();
    end
endmodule : fpio_top_tb
`default_nettype wire
